// ### src/ics_selector.v
// Input clock selector: chooses which of four clock inputs feeds the loop.
// Assumes a one-cycle register port and fault flags synchronous to CORE_CLK.
//
// Behaviour
// [R1] Policy code 0 gives manual selection from pins or register field.
// [R2] Select-control bit 0 picks pins (0, default) or register field (1).
// [R3] Pin pair 00..11 selects input 0..3; outside party drives the pins.
// [R4] Feedback alignment mode turns input 3 into feedback; never a source.
// [R5] Manual choice without a valid clock drops the loop into holdover.
// [R6] Policy 1 runs automatic non-revertive, policy 2 automatic revertive.
// [R7] Automatic selection ignores both the select pins and register field.
// [R8] Automatic selection only considers inputs without unmasked faults.
// [R9] No valid input under automatic selection means holdover or free-run.
// [R10] Revertive: always the best-ranked valid input, switching up at once.
// [R11] Non-revertive: keep current while valid, else take best valid.
// [R12] Automatic selection is unavailable in feedback alignment mode.
// [R13] Signal-loss ignore bit per input: 0 counts loss, 1 ignores it.
// [R14] Frequency-fault ignore bit per input: 0 counts fault, 1 ignores it.
// [R15] Rank 1..4 descending importance, 0 never selected, 5..7 reserved.
// [R16] Buffer enable bit per input: 1 powers buffer up, 0 down.
// [R17] Format bit per input: 0 standard, 1 narrow-pulse CMOS.
// [R18] Threshold bit per input: 0 low CMOS, 1 standard for 1.8 V.
// [R19] Register select code 0..3 maps to input 0..3; 4..7 reserved.
// [R20] Equal best ranks resolve to the lowest-numbered input.
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`include "ics_regs.vh"

module ics_selector #(
	parameter N = 4
) (
	// Clock and reset
	input  wire         CORE_CLK,
	input  wire         RST,
	// Register port
	input  wire [11:0]  REG_ADDR,
	input  wire [7:0]   REG_WDATA,
	input  wire         REG_WR,
	input  wire         REG_RD,
	output reg  [7:0]   REG_RDATA,
	// External select pins and fault monitors
	input  wire [1:0]   SEL_PINS,
	input  wire [N-1:0] SIGNAL_ABSENT_FLAG,
	input  wire [N-1:0] FREQUENCY_FAULT_FLAG,
	// Loop source control
	output reg  [1:0]   ACTIVE_INPUT,
	output reg          HOLDOVER_REQ,
	output reg          SWITCH_PULSE,
	output reg          FEEDBACK_ALIGNMENT_MODE,
	// Input buffer control
	output reg  [N-1:0] BUF_ENABLE,
	output reg  [N-1:0] BUF_PULSED_FORMAT,
	output reg  [N-1:0] THRESHOLD_LEVEL_BITS
);

	// Selection states, one-hot: MANUAL follows pins or register field,
	// AUTO follows the rank race and HOLD parks the loop with no usable source.
	// Every entry into AUTO passes through HOLD, so a policy change never
	// lands on a half-made decision.
	localparam [2:0] ST_MANUAL = 3'h1;
	localparam [2:0] ST_AUTO   = 3'h2;
	localparam [2:0] ST_HOLD   = 3'h4;

	// Software-visible configuration
	reg         select_from_register_flag_reg;
	reg [2:0]   select_code_reg;
	reg [1:0]   switch_mode_reg;
	reg [N-1:0] signal_loss_ignore_bits_reg;
	reg [N-1:0] freq_fault_ignore_bits_reg;
	reg [2:0]   source_rank_0_reg;
	reg [2:0]   source_rank_1_reg;
	reg [2:0]   source_rank_2_reg;
	reg [2:0]   source_rank_3_reg;
	reg         fb_mode_reg;

	// Selection state
	reg [2:0]   state_reg;
	reg [2:0]   state_next;
	reg [1:0]   sel_next;
	reg         hold_next;
	reg         switch_next;
	reg [7:0]   rdata_next;

	// Derived terms
	wire [3*N-1:0] rank_bus;
	wire [N-1:0]   live_ok;
	wire [N-1:0]   auto_ok;
	wire [1:0]     best_sel;
	wire           best_found;
	wire           auto_req;
	wire           auto_en;
	wire           revertive;
	wire [1:0]     manual_sel;
	wire           manual_code_ok;
	wire           manual_ok;
	wire [7:0]     status_word;

	assign rank_bus = {source_rank_3_reg, source_rank_2_reg,
		source_rank_1_reg, source_rank_0_reg};

	// Policy decode; code 3 is reserved and treated as manual
	assign auto_req = (switch_mode_reg == `ICS_MODE_NONREVERT) ||
		(switch_mode_reg == `ICS_MODE_REVERT); // [R6]
	// Feedback alignment forces the manual path
	assign auto_en = auto_req & ~fb_mode_reg; // [R12]
	assign revertive = (switch_mode_reg == `ICS_MODE_REVERT); // [R6]

	// Manual source: pins decode directly, register code through its map
	assign manual_sel = select_from_register_flag_reg ?
		select_code_reg[1:0] : SEL_PINS; // [R1] [R2] [R3] [R19]
	// Reserved register codes leave no usable source
	assign manual_code_ok = ~select_from_register_flag_reg |
		~select_code_reg[2]; // [R19]
	// Masks only steer the automatic race; a manual choice honours raw faults
	assign manual_ok = manual_code_ok & live_ok[manual_sel]; // [R4] [R5]

	// Status image: qualified inputs, spare zero, holdover and current source
	assign status_word = {auto_ok, 1'b0, HOLDOVER_REQ, ACTIVE_INPUT};

	// Per-input qualification
	ics_validity #(
		.N (N)
	) u_validity (
		.buf_en        (BUF_ENABLE),
		.signal_absent (SIGNAL_ABSENT_FLAG),
		.freq_fault    (FREQUENCY_FAULT_FLAG),
		.loss_ignore   (signal_loss_ignore_bits_reg),
		.freq_ignore   (freq_fault_ignore_bits_reg),
		.rank          (rank_bus),
		.fb_mode       (fb_mode_reg),
		.live_ok       (live_ok),
		.auto_ok       (auto_ok)
	);

	// Best-ranked candidate for automatic switching
	ics_rank_pick #(
		.N (N)
	) u_pick (
		.cand  (auto_ok),
		.rank  (rank_bus),
		.best  (best_sel),
		.found (best_found)
	);

	// Source selection; the pins and select field are not looked at in auto.
	// Leaving automatic mode applies the manual choice at once, so the pins
	// are obeyed on the very next edge instead of idling on the old source.
	always @* begin
		state_next = state_reg;
		sel_next = ACTIVE_INPUT;
		hold_next = HOLDOVER_REQ;
		switch_next = 1'b0;
		case (state_reg)
			ST_MANUAL: begin
				if (auto_en) begin
					// One parked cycle marks the hand-over to the rank race
					state_next = ST_HOLD;
					hold_next = 1'b1;
				end else begin
					sel_next = manual_sel; // [R1]
					hold_next = ~manual_ok; // [R5]
				end
			end
			ST_AUTO: begin
				if (!auto_en) begin
					// Policy dropped back to manual: obey it without a spare cycle
					state_next = ST_MANUAL;
					sel_next = manual_sel; // [R1]
					hold_next = ~manual_ok; // [R5]
				end else if (!best_found) begin
					state_next = ST_HOLD; // [R9]
					hold_next = 1'b1;
				end else if (revertive) begin
					sel_next = best_sel; // [R7] [R10]
					hold_next = 1'b0;
				end else if (!auto_ok[ACTIVE_INPUT]) begin
					sel_next = best_sel; // [R11]
					hold_next = 1'b0;
				end else begin
					hold_next = 1'b0; // [R11]
				end
			end
			ST_HOLD: begin
				if (!auto_en) begin
					// Same immediate hand-back as from the automatic state
					state_next = ST_MANUAL;
					sel_next = manual_sel; // [R1]
					hold_next = ~manual_ok; // [R5]
				end else if (best_found) begin
					state_next = ST_AUTO; // [R8]
					sel_next = best_sel;
					hold_next = 1'b0;
				end else begin
					hold_next = 1'b1; // [R9]
				end
			end
			default: begin
				state_next = ST_MANUAL;
				hold_next = 1'b1;
			end
		endcase
		// A switchover is flagged when a live source replaces another or ends holdover
		if (!hold_next && (sel_next != ACTIVE_INPUT || HOLDOVER_REQ)) begin
			switch_next = 1'b1;
		end
	end

	// Selection outputs; automatic holdover keeps the last source visible, manual holdover shows the chosen input.
	// The loop must only trust ACTIVE_INPUT while HOLDOVER_REQ is low.
	always @(posedge CORE_CLK) begin
		if (RST) begin
			state_reg <= ST_MANUAL;
			ACTIVE_INPUT <= 2'h0;
			HOLDOVER_REQ <= 1'b1;
			SWITCH_PULSE <= 1'b0;
		end else begin
			state_reg <= state_next;
			ACTIVE_INPUT <= sel_next;
			HOLDOVER_REQ <= hold_next;
			SWITCH_PULSE <= switch_next;
		end
	end

	// Register writes; reserved bits are not stored and read back as zero.
	// Buffer controls drive their pins straight from these flops, so a write
	// reaches the input buffers on the edge that accepts it.
	always @(posedge CORE_CLK) begin
		if (RST) begin
			select_from_register_flag_reg <= 1'b0; // [R2]
			select_code_reg <= 3'h0;
			switch_mode_reg <= `ICS_RST_SWITCH_MODE;
			signal_loss_ignore_bits_reg <= 4'h0;
			freq_fault_ignore_bits_reg <= 4'h0;
			source_rank_0_reg <= `ICS_RST_RANK_0;
			source_rank_1_reg <= `ICS_RST_RANK_1;
			source_rank_2_reg <= `ICS_RST_RANK_2;
			source_rank_3_reg <= `ICS_RST_RANK_3;
			fb_mode_reg <= `ICS_RST_FB_EN;
			BUF_ENABLE <= `ICS_RST_BUF_CFG;
			BUF_PULSED_FORMAT <= 4'h0;
			THRESHOLD_LEVEL_BITS <= `ICS_RST_THRESHOLD;
			FEEDBACK_ALIGNMENT_MODE <= `ICS_RST_FB_EN;
		end else begin
			FEEDBACK_ALIGNMENT_MODE <= fb_mode_reg; // [R4]
			if (REG_WR) begin
				case (REG_ADDR)
					`ICS_ADDR_SEL_CTRL: begin
						select_from_register_flag_reg <=
							REG_WDATA[`ICS_SEL_SRC_BIT]; // [R2]
						select_code_reg <=
							REG_WDATA[`ICS_SEL_CODE_MSB:`ICS_SEL_CODE_LSB]; // [R19]
					end
					`ICS_ADDR_SWITCH_MODE: begin
						switch_mode_reg <= REG_WDATA[`ICS_MODE_MSB:`ICS_MODE_LSB];
					end
					`ICS_ADDR_FAULT_MASK: begin
						signal_loss_ignore_bits_reg <=
							REG_WDATA[`ICS_LOSS_MSK_MSB:`ICS_LOSS_MSK_LSB]; // [R13]
						freq_fault_ignore_bits_reg <=
							REG_WDATA[`ICS_FREQ_MSK_MSB:`ICS_FREQ_MSK_LSB]; // [R14]
					end
					`ICS_ADDR_RANK_LO: begin
						source_rank_0_reg <=
							REG_WDATA[`ICS_RANK_A_MSB:`ICS_RANK_A_LSB]; // [R15]
						source_rank_1_reg <=
							REG_WDATA[`ICS_RANK_B_MSB:`ICS_RANK_B_LSB];
					end
					`ICS_ADDR_RANK_HI: begin
						source_rank_2_reg <=
							REG_WDATA[`ICS_RANK_A_MSB:`ICS_RANK_A_LSB]; // [R15]
						source_rank_3_reg <=
							REG_WDATA[`ICS_RANK_B_MSB:`ICS_RANK_B_LSB];
					end
					`ICS_ADDR_FB_CTRL: begin
						fb_mode_reg <= REG_WDATA[`ICS_FB_EN_BIT];
					end
					`ICS_ADDR_BUF_CFG: begin
						BUF_ENABLE <=
							REG_WDATA[`ICS_BUF_EN_MSB:`ICS_BUF_EN_LSB]; // [R16]
						BUF_PULSED_FORMAT <=
							REG_WDATA[`ICS_BUF_FMT_MSB:`ICS_BUF_FMT_LSB]; // [R17]
					end
					`ICS_ADDR_THRESHOLD: begin
						THRESHOLD_LEVEL_BITS <=
							REG_WDATA[`ICS_THR_MSB:`ICS_THR_LSB]; // [R18]
					end
					default: begin
						select_code_reg <= select_code_reg;
					end
				endcase
			end
		end
	end

	// Read mux; unmapped offsets read as zero and the status image reads live, unchanged by writes
	always @* begin
		rdata_next = 8'h00;
		case (REG_ADDR)
			`ICS_ADDR_SEL_CTRL: begin
				rdata_next = {4'h0, select_code_reg,
					select_from_register_flag_reg};
			end
			`ICS_ADDR_SWITCH_MODE: begin
				rdata_next = {6'h00, switch_mode_reg};
			end
			`ICS_ADDR_FAULT_MASK: begin
				rdata_next = {freq_fault_ignore_bits_reg,
					signal_loss_ignore_bits_reg};
			end
			`ICS_ADDR_RANK_LO: begin
				rdata_next = {1'b0, source_rank_1_reg, 1'b0, source_rank_0_reg};
			end
			`ICS_ADDR_RANK_HI: begin
				rdata_next = {1'b0, source_rank_3_reg, 1'b0, source_rank_2_reg};
			end
			`ICS_ADDR_FB_CTRL: begin
				rdata_next = {7'h00, fb_mode_reg};
			end
			`ICS_ADDR_STATUS: begin
				// Live view of qualification and the chosen source
				rdata_next = status_word;
			end
			`ICS_ADDR_BUF_CFG: begin
				rdata_next = {BUF_PULSED_FORMAT, BUF_ENABLE};
			end
			`ICS_ADDR_THRESHOLD: begin
				rdata_next = {THRESHOLD_LEVEL_BITS, 4'h0};
			end
			default: begin
				rdata_next = 8'h00;
			end
		endcase
	end

	// Read data stand only in the cycle after the strobe
	// Returning zero outside that cycle keeps a stale word from looking fresh
	always @(posedge CORE_CLK) begin
		if (RST) begin
			REG_RDATA <= 8'h00;
		end else if (REG_RD) begin
			REG_RDATA <= rdata_next;
		end else begin
			REG_RDATA <= 8'h00;
		end
	end

endmodule

// ### src/ics_regs.vh
// Register map, field positions and reset values of the input clock selector.
// Assumes inclusion by bare name from every selector source file except the rank picker.
`ifndef ICS_REGS_VH
`define ICS_REGS_VH

// Register offsets on the 12-bit register port
`define ICS_ADDR_SEL_CTRL    12'h052A
`define ICS_ADDR_SWITCH_MODE 12'h0536
`define ICS_ADDR_FAULT_MASK  12'h0537
`define ICS_ADDR_RANK_LO     12'h0538
`define ICS_ADDR_RANK_HI     12'h0539
`define ICS_ADDR_FB_CTRL     12'h0540
`define ICS_ADDR_STATUS      12'h0541
`define ICS_ADDR_BUF_CFG     12'h0949
`define ICS_ADDR_THRESHOLD   12'h094F

// Field positions
`define ICS_SEL_SRC_BIT      0
`define ICS_SEL_CODE_LSB     1
`define ICS_SEL_CODE_MSB     3
`define ICS_MODE_LSB         0
`define ICS_MODE_MSB         1
`define ICS_LOSS_MSK_LSB     0
`define ICS_LOSS_MSK_MSB     3
`define ICS_FREQ_MSK_LSB     4
`define ICS_FREQ_MSK_MSB     7
`define ICS_RANK_A_LSB       0
`define ICS_RANK_A_MSB       2
`define ICS_RANK_B_LSB       4
`define ICS_RANK_B_MSB       6
`define ICS_BUF_EN_LSB       0
`define ICS_BUF_EN_MSB       3
`define ICS_BUF_FMT_LSB      4
`define ICS_BUF_FMT_MSB      7
`define ICS_THR_LSB          4
`define ICS_THR_MSB          7
`define ICS_FB_EN_BIT        0

// Switching policy codes
`define ICS_MODE_MANUAL      2'h0
`define ICS_MODE_NONREVERT   2'h1
`define ICS_MODE_REVERT      2'h2

// Rank codes
`define ICS_RANK_NEVER       3'h0
`define ICS_RANK_LAST        3'h4

// Reset values
`define ICS_RST_SEL_CTRL     8'h00
`define ICS_RST_SWITCH_MODE  2'h0
`define ICS_RST_FAULT_MASK   8'h00
`define ICS_RST_RANK_0       3'h1
`define ICS_RST_RANK_1       3'h2
`define ICS_RST_RANK_2       3'h3
`define ICS_RST_RANK_3       3'h4
`define ICS_RST_BUF_CFG      4'hF
`define ICS_RST_THRESHOLD    4'h0
`define ICS_RST_FB_EN        1'h0

`endif

// ### src/ics_validity.v
// Per-input qualification for the input clock selector.
// Assumes fault flags are synchronous to the core clock; purely combinational.
`timescale 1ns/1ps
`include "ics_regs.vh"

module ics_validity #(
	parameter N = 4
) (
	// Per-input status and configuration
	input  wire [N-1:0]   buf_en,
	input  wire [N-1:0]   signal_absent,
	input  wire [N-1:0]   freq_fault,
	input  wire [N-1:0]   loss_ignore,
	input  wire [N-1:0]   freq_ignore,
	input  wire [3*N-1:0] rank,
	input  wire           fb_mode,
	// Qualification results
	output wire [N-1:0]   live_ok,
	output wire [N-1:0]   auto_ok
);

	genvar i;
	generate
		for (i = 0; i < N; i = i + 1) begin : g_in
			wire [2:0] r;
			wire       faults;
			wire       usable;
			assign r = rank[3*i+2:3*i];
			// Masked faults do not count against an input
			assign faults = (signal_absent[i] & ~loss_ignore[i]) |
				(freq_fault[i] & ~freq_ignore[i]); // [R8] [R13] [R14]
			// A powered-down buffer carries no clock
			assign usable = buf_en[i] & ~(fb_mode & (i == N - 1)); // [R4] [R16]
			assign live_ok[i] = usable & ~signal_absent[i] & ~freq_fault[i];
			// Rank 0 and reserved codes keep the input out of the race
			assign auto_ok[i] = usable & ~faults & (r != `ICS_RANK_NEVER) &
				(r <= `ICS_RANK_LAST); // [R15]
		end
	endgenerate

endmodule

// ### src/ics_rank_pick.v
// Picks the best-ranked qualified input for automatic switching.
// Assumes the qualification vector already excludes rank 0 and reserved codes.
`timescale 1ns/1ps

module ics_rank_pick #(
	parameter N = 4
) (
	// Candidates
	input  wire [N-1:0]   cand,
	input  wire [3*N-1:0] rank,
	// Winner
	output reg  [1:0]     best,
	output reg            found
);

	integer   k;
	reg [2:0] best_rank;

	// Scan from the top so that on equal ranks the lowest index wins last
	always @* begin
		best = 2'h0;
		found = 1'b0;
		best_rank = 3'h7;
		for (k = N - 1; k >= 0; k = k - 1) begin
			if (cand[k] && (rank[3*k +: 3] <= best_rank)) begin // [R20]
				best = k[1:0];
				best_rank = rank[3*k +: 3];
				found = 1'b1;
			end
		end
	end

endmodule

// ### bench/ics_sel_assertions.sv
// Checker for the input clock selector, watching only the top-level ports.
// Assumes the one-cycle register port; shadows the selection controls itself.
`timescale 1ns/1ps
`include "ics_regs.vh"

module ics_sel_assertions #(
	parameter N = 4
) (
	// Clock, reset and register port
	input wire         CORE_CLK,
	input wire         RST,
	input wire [11:0]  REG_ADDR,
	input wire [7:0]   REG_WDATA,
	input wire         REG_WR,
	input wire         REG_RD,
	input wire [7:0]   REG_RDATA,
	// Pins and fault monitors
	input wire [1:0]   SEL_PINS,
	input wire [N-1:0] SIGNAL_ABSENT_FLAG,
	input wire [N-1:0] FREQUENCY_FAULT_FLAG,
	// Selection and buffer outputs
	input wire [1:0]   ACTIVE_INPUT,
	input wire         HOLDOVER_REQ,
	input wire         SWITCH_PULSE,
	input wire         FEEDBACK_ALIGNMENT_MODE,
	input wire [N-1:0] BUF_ENABLE,
	input wire [N-1:0] BUF_PULSED_FORMAT,
	input wire [N-1:0] THRESHOLD_LEVEL_BITS
);
	reg  [1:0] mode_reg;
	reg        src_reg;
	reg  [2:0] code_reg;
	reg        fb_reg;
	wire       man = (mode_reg == 2'h0) || (mode_reg == 2'h3) || fb_reg;
	wire       pin = man && !src_reg;

	// Shadow copies change on the write edge, exactly like the design's registers
	always @(posedge CORE_CLK) begin
		if (RST) begin
			mode_reg <= 2'h0;
			src_reg <= 1'b0;
			code_reg <= 3'h0;
			fb_reg <= 1'b0;
		end else if (REG_WR) begin
			if (REG_ADDR == `ICS_ADDR_SWITCH_MODE)
				mode_reg <= REG_WDATA[1:0];
			if (REG_ADDR == `ICS_ADDR_SEL_CTRL)
				{code_reg, src_reg} <= REG_WDATA[3:0];
			if (REG_ADDR == `ICS_ADDR_FB_CTRL)
				fb_reg <= REG_WDATA[0];
		end
	end

	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RST);

	a_pin_select: assert property (
		pin |=> HOLDOVER_REQ || (ACTIVE_INPUT == $past(SEL_PINS))) else $error("pin choice lost");
	a_loss_hold: assert property (
		pin && SIGNAL_ABSENT_FLAG[SEL_PINS] |=> HOLDOVER_REQ) else $error("dead input kept");
	a_reg_select: assert property (
		man && src_reg |=> HOLDOVER_REQ ||
		(($past(code_reg) < 3'h4) && (ACTIVE_INPUT == $past(code_reg[1:0]))))
		else $error("register choice lost");
	a_fb_in3: assert property (
		pin && fb_reg && (SEL_PINS == 2'h3) |=> HOLDOVER_REQ) else $error("feedback pin used");
	a_fb_copy: assert property (
		REG_WR && (REG_ADDR == `ICS_ADDR_FB_CTRL) |=> ##1
		{7'h00, FEEDBACK_ALIGNMENT_MODE} == ($past(REG_WDATA, 2) & 8'h01)) else $error("fb copy");
	a_buf_write: assert property (
		REG_WR && (REG_ADDR == `ICS_ADDR_BUF_CFG) |=>
		{BUF_PULSED_FORMAT, BUF_ENABLE} == $past(REG_WDATA)) else $error("buffer setup");
	a_thr_write: assert property (
		REG_WR && (REG_ADDR == `ICS_ADDR_THRESHOLD) |=>
		THRESHOLD_LEVEL_BITS == ($past(REG_WDATA) >> 4)) else $error("threshold setup");
	a_buf_read: assert property (
		REG_RD && (REG_ADDR == `ICS_ADDR_BUF_CFG) |=>
		REG_RDATA == {BUF_PULSED_FORMAT, BUF_ENABLE}) else $error("buffer readback");
	a_pulse_live: assert property (
		SWITCH_PULSE |-> !HOLDOVER_REQ) else $error("switch pulse in holdover");
	// A pulse marks exactly the cycles in which a live source is newly taken
	a_switch_flag: assert property (
		SWITCH_PULSE == (!HOLDOVER_REQ &&
		((ACTIVE_INPUT != $past(ACTIVE_INPUT)) || $past(HOLDOVER_REQ))))
		else $error("switch pulse wrong");
endmodule

bind ics_selector ics_sel_assertions #(.N(N)) u_chk (.CORE_CLK(CORE_CLK), .RST(RST),
	.REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
	.REG_RDATA(REG_RDATA), .SEL_PINS(SEL_PINS), .SIGNAL_ABSENT_FLAG(SIGNAL_ABSENT_FLAG),
	.FREQUENCY_FAULT_FLAG(FREQUENCY_FAULT_FLAG), .ACTIVE_INPUT(ACTIVE_INPUT),
	.HOLDOVER_REQ(HOLDOVER_REQ), .SWITCH_PULSE(SWITCH_PULSE),
	.FEEDBACK_ALIGNMENT_MODE(FEEDBACK_ALIGNMENT_MODE), .BUF_ENABLE(BUF_ENABLE),
	.BUF_PULSED_FORMAT(BUF_PULSED_FORMAT), .THRESHOLD_LEVEL_BITS(THRESHOLD_LEVEL_BITS));

// ### bench/ics_source_model.sv
// Model of the upstream clock sources and the board's select pins.
// Assumes the bench asks for levels; slow boards show them a cycle late.
`timescale 1ns/1ps

module ics_source_model (
	// Clock and requests from the bench
	input wire        clk,
	input wire        slow,
	input wire [1:0]  want_sel,
	input wire [3:0]  want_loss,
	input wire [3:0]  want_freq,
	// Levels seen by the selector
	output reg [1:0]  sel_pins = 2'h0,
	output reg [3:0]  loss_flags = 4'h0,
	output reg [3:0]  freq_flags = 4'h0
);
	reg [9:0] late_reg = 10'h000;

	// Pins and monitors move only after an edge, as real board levels would
	always @(posedge clk) begin
		late_reg <= {want_sel, want_loss, want_freq};
		{sel_pins, loss_flags, freq_flags} <= slow ? late_reg : {want_sel, want_loss, want_freq};
	end
endmodule

// ### bench/test_ics_selector.sv
// Self-checking bench for the input clock selector; every check is a read.
// Assumes the source model drives pins and flags, the bench drives registers.
`timescale 1ns/1ps
`include "ics_regs.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; \
	$display("Error t=%0t got %h exp %h", $time, g, e); end end

module test_ics_selector;
	reg         CORE_CLK = 1'b0;
	reg         RST = 1'b1;
	reg  [11:0] REG_ADDR = 12'h000;
	reg  [7:0]  REG_WDATA = 8'h00;
	reg         REG_WR = 1'b0;
	reg         REG_RD = 1'b0;
	wire [7:0]  REG_RDATA;
	wire [1:0]  SEL_PINS, ACTIVE_INPUT;
	wire [3:0]  SIGNAL_ABSENT_FLAG, FREQUENCY_FAULT_FLAG, BUF_ENABLE, BUF_PULSED_FORMAT, THR;
	wire        HOLDOVER_REQ, SWITCH_PULSE, FB_MODE;
	reg  [1:0]  want_sel = 2'h0;
	reg  [3:0]  want_loss = 4'h0;
	reg  [3:0]  want_freq = 4'h0;
	reg         slow = 1'b0;
	reg         rd_d = 1'b0;
	reg  [7:0]  seed = 8'h53;
	reg  [15:0] exp_q[$];
	reg  [15:0] e;
	integer     errors = 0;
	integer     compares = 0;
	integer     i;

	initial forever #2 CORE_CLK = ~CORE_CLK;

	ics_selector #(.N(4)) uut (.CORE_CLK(CORE_CLK), .RST(RST), .REG_ADDR(REG_ADDR),
		.REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
		.SEL_PINS(SEL_PINS), .SIGNAL_ABSENT_FLAG(SIGNAL_ABSENT_FLAG),
		.FREQUENCY_FAULT_FLAG(FREQUENCY_FAULT_FLAG), .ACTIVE_INPUT(ACTIVE_INPUT),
		.HOLDOVER_REQ(HOLDOVER_REQ), .SWITCH_PULSE(SWITCH_PULSE),
		.FEEDBACK_ALIGNMENT_MODE(FB_MODE), .BUF_ENABLE(BUF_ENABLE),
		.BUF_PULSED_FORMAT(BUF_PULSED_FORMAT), .THRESHOLD_LEVEL_BITS(THR));

	ics_source_model board (.clk(CORE_CLK), .slow(slow), .want_sel(want_sel),
		.want_loss(want_loss), .want_freq(want_freq), .sel_pins(SEL_PINS),
		.loss_flags(SIGNAL_ABSENT_FLAG), .freq_flags(FREQUENCY_FAULT_FLAG));

	function [7:0] lfsr(input [7:0] v);
		lfsr = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction

	task wr(input [11:0] a, input [7:0] d);
		begin
			@(posedge CORE_CLK);
			REG_WR <= 1'b1;
			REG_ADDR <= a;
			REG_WDATA <= d;
			@(posedge CORE_CLK);
			REG_WR <= 1'b0;
		end
	endtask

	// The expectation is queued before the strobe, so the checker never runs dry
	task rd(input [11:0] a, input [7:0] x, input [7:0] m);
		begin
			exp_q.push_back({x, m});
			@(posedge CORE_CLK);
			REG_RD <= 1'b1;
			REG_ADDR <= a;
			@(posedge CORE_CLK);
			REG_RD <= 1'b0;
		end
	endtask

	// Give the model and the selector time to settle, then read status
	task st(input [7:0] x, input [7:0] m);
		begin
			repeat (6) @(posedge CORE_CLK);
			rd(`ICS_ADDR_STATUS, x, m);
		end
	endtask

	task done(input [8*8-1:0] n);
		$display("test %0s done", n);
	endtask

	task end_sim;
		begin
			$display("compares %0d errors %0d", compares, errors);
			if (errors == 0 && compares > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask

	// Read data stands only in the cycle after the strobe
	always @(posedge CORE_CLK) begin
		if (rd_d) begin
			e = exp_q.pop_front();
			`CHK(REG_RDATA & e[7:0], e[15:8])
		end
		rd_d <= REG_RD;
	end

	initial begin
		#40000;
		errors = errors + 1;
		end_sim;
	end

	initial begin
		repeat (10) @(posedge CORE_CLK);
		RST <= 1'b0;
		rd(`ICS_ADDR_SEL_CTRL, 8'h00, 8'hFF);
		rd(`ICS_ADDR_SWITCH_MODE, 8'h00, 8'h03);
		rd(`ICS_ADDR_FAULT_MASK, 8'h00, 8'hFF);
		rd(`ICS_ADDR_RANK_LO, 8'h21, 8'h77);
		rd(`ICS_ADDR_RANK_HI, 8'h43, 8'h77);
		rd(`ICS_ADDR_BUF_CFG, 8'h0F, 8'hFF);
		rd(`ICS_ADDR_THRESHOLD, 8'h00, 8'hF0);
		rd(12'h123, 8'h00, 8'hFF);
		st(8'hF0, 8'hFF);
		done("reset");
		for (i = 0; i < 4; i = i + 1) begin
			seed = lfsr(seed);
			wr(`ICS_ADDR_THRESHOLD, seed);
			rd(`ICS_ADDR_THRESHOLD, seed & 8'hF0, 8'hF0);
			wr(`ICS_ADDR_BUF_CFG, seed);
			rd(`ICS_ADDR_BUF_CFG, seed, 8'hFF);
			wr(`ICS_ADDR_FAULT_MASK, seed);
			rd(`ICS_ADDR_FAULT_MASK, seed, 8'hFF);
		end
		wr(`ICS_ADDR_STATUS, 8'h07);
		wr(`ICS_ADDR_BUF_CFG, 8'h0F);
		wr(`ICS_ADDR_FAULT_MASK, 8'h00);
		st(8'hF0, 8'hFF);
		done("regs");
		for (i = 0; i < 4; i = i + 1) begin
			slow <= i[0];
			want_sel <= i[1:0];
			st({6'h00, i[1:0]}, 8'h07);
		end
		want_loss <= 4'h8;
		st(8'h04, 8'h04);
		for (i = 0; i < 8; i = i + 1) begin
			wr(`ICS_ADDR_SEL_CTRL, {4'h0, i[2:0], 1'b1});
			st((i < 3) ? {6'h00, i[1:0]} : 8'h04, (i < 3) ? 8'h07 : 8'h04);
		end
		done("manual");
		want_loss <= 4'h0;
		wr(`ICS_ADDR_SEL_CTRL, 8'h00);
		wr(`ICS_ADDR_FB_CTRL, 8'h01);
		st(8'h04, 8'h04);
		wr(`ICS_ADDR_SWITCH_MODE, 8'h02);
		want_sel <= 2'h1;
		st(8'h01, 8'h07);
		wr(`ICS_ADDR_FB_CTRL, 8'h00);
		st(8'hF0, 8'hFF);
		want_loss <= 4'h1;
		st(8'hE1, 8'hFF);
		want_loss <= 4'h0;
		st(8'hF0, 8'hFF);
		wr(`ICS_ADDR_FAULT_MASK, 8'h02);
		want_loss <= 4'h3;
		st(8'hE1, 8'hFF);
		want_freq <= 4'h2;
		st(8'hC2, 8'hFF);
		want_loss <= 4'hF;
		st(8'h04, 8'hFC);
		want_loss <= 4'h0;
		want_freq <= 4'h0;
		wr(`ICS_ADDR_RANK_LO, 8'h10);
		wr(`ICS_ADDR_RANK_HI, 8'h11);
		st(8'hE1, 8'hFF);
		wr(`ICS_ADDR_RANK_LO, 8'h00);
		wr(`ICS_ADDR_RANK_HI, 8'h51);
		st(8'h42, 8'hFF);
		done("revert");
		// Policy first: input 2 stays chosen although input 0 outranks it again
		wr(`ICS_ADDR_SWITCH_MODE, 8'h01);
		wr(`ICS_ADDR_RANK_LO, 8'h21);
		wr(`ICS_ADDR_RANK_HI, 8'h43);
		st(8'hF2, 8'hFF);
		want_loss <= 4'h4;
		st(8'hB0, 8'hFF);
		want_loss <= 4'h1;
		st(8'hE1, 8'hFF);
		want_loss <= 4'h0;
		st(8'hF1, 8'hFF);
		want_sel <= 2'h2;
		wr(`ICS_ADDR_SWITCH_MODE, 8'h03);
		st(8'h02, 8'h07);
		done("nonrev");
		end_sim;
	end
endmodule
